// >>> logic/cpu_regs_pkg.sv
package cpu_regs_pkg;

  // Widths
  localparam int unsigned PC_W  = 20;
  localparam int unsigned SP_W  = 16;
  localparam int unsigned BANKS = 4;
  localparam int unsigned REGS  = 8;

  // Reset values
  localparam logic [7:0]  FLAGS_RST = 8'h06;
  localparam logic [3:0]  DEXT_RST  = 4'hf;
  localparam logic [3:0]  CEXT_RST  = 4'h0;
  localparam logic [19:0] VEC_LO_A  = 20'h00000;
  localparam logic [19:0] VEC_HI_A  = 20'h00001;

  // Working register window in data space
  localparam logic [19:0] WREG_BASE = 20'hffee0;
  localparam logic [19:0] WREG_LAST = 20'hffeff;
  localparam logic [3:0]  TOP_SEG   = 4'hf;

  // Flag bit positions
  localparam int unsigned F_CY  = 0;
  localparam int unsigned F_SL0 = 1;
  localparam int unsigned F_SL1 = 2;
  localparam int unsigned F_BS0 = 3;
  localparam int unsigned F_HC  = 4;
  localparam int unsigned F_BS1 = 5;
  localparam int unsigned F_Z   = 6;
  localparam int unsigned F_IG  = 7;

  localparam logic [1:0]  STACK_STEP = 2'd2;

  // Program counter source
  typedef enum logic [1:0] {
    PC_HOLD   = 2'b00,
    PC_SEQ    = 2'b01,
    PC_BR_IMM = 2'b10,
    PC_BR_REG = 2'b11
  } pc_op_t;

  // Stack pointer operation
  typedef enum logic [1:0] {
    SP_HOLD = 2'b00,
    SP_LOAD = 2'b01,
    SP_PUSH = 2'b10,
    SP_POP  = 2'b11
  } sp_op_t;

  // Flag word update request from the decoder / interrupt logic
  typedef struct packed {
    logic       wr_all;      // Load whole word (restore or direct write)
    logic [7:0] wr_val;
    logic       upd_z;
    logic       upd_hc;
    logic       upd_cy;
    logic [7:0] result;
    logic       hc_out;      // Carry out of / borrow into bit 3
    logic       cy_val;
    logic       bank_wr;
    logic [1:0] bank_val;
    logic       gate_on;
    logic       gate_off;
    logic       irq_taken;
  } flag_req_t;

  // Working register access
  typedef struct packed {
    logic        we;
    logic        pair;       // 16-bit pair access
    logic [2:0]  idx;        // Pair uses idx[2:1]
    logic [15:0] wdata;
  } wreg_req_t;

endpackage : cpu_regs_pkg

// >>> logic/work_reg_banks.sv
module work_reg_banks
  import cpu_regs_pkg::*;
(
  input  wire logic       clk_i,       // Core clock
  input  wire logic [1:0] bank_i,      // Active bank
  input  wire wreg_req_t  req_i,       // Access by name
  input  wire logic       mem_we_i,    // Byte write by data address
  input  wire logic [4:0] mem_ofs_i,   // Offset inside the window
  input  wire logic [7:0] mem_wdata_i, // Byte write data
  output logic [15:0]     rdata_o,     // Named read, pair or byte
  output logic [7:0]      mem_rdata_o  // Byte read by data address
);

  // Byte array: bank*8+reg equals the offset from the window base
  logic [7:0] mem_q [BANKS*REGS];
  logic [4:0] a_lo;
  logic [4:0] a_hi;

  // Pair low byte sits at the even register, high at the odd
  always_comb begin
    a_lo = req_i.pair ? {bank_i, req_i.idx[2:1], 1'b0} : {bank_i, req_i.idx};
    a_hi = {bank_i, req_i.idx[2:1], 1'b1};
  end

  // Named write has priority over an address write to the same byte
  always_ff @(posedge clk_i) begin
    if (mem_we_i) begin
      mem_q[mem_ofs_i] <= mem_wdata_i;
    end
    if (req_i.we) begin
      mem_q[a_lo] <= req_i.wdata[7:0];
      if (req_i.pair) begin
        mem_q[a_hi] <= req_i.wdata[15:8];
      end
    end
  end

  // Reads are combinational, the array holds no reset value
  always_comb begin
    rdata_o     = req_i.pair ? {mem_q[a_hi], mem_q[a_lo]}
                             : {8'h00, mem_q[a_lo]};
    mem_rdata_o = mem_q[mem_ofs_i];
  end

endmodule : work_reg_banks

// >>> logic/cpu_control_register_set.sv
// Contract
// RQ1: Instruction address counter is 20 bits, advances by instruction length.
// RQ2: Reset loads counter from vector bytes 0 (low) and 1 (high).
// RQ3: Branch replaces counter with immediate or register target.
// RQ4: Flag word is 8 bits, reset value 06H.
// RQ5: Flag bits 7..0: gate, zero, bank1, hcarry, bank0, level1, level0, carry.
// RQ6: Flags pushed on interrupt and save, popped on returns and restore.
// RQ7: Gate clear refuses maskable requests; set defers to level and priority.
// RQ8: Disable and acceptance clear the gate; enable sets it.
// RQ9: Zero flag set on zero result, cleared otherwise.
// RQ10: Bank bits pick one of four banks; bank switch writes them.
// RQ11: Half carry set on bit 3 carry or borrow, else cleared.
// RQ12: Requests below the service level are refused; gate still applies.
// RQ13: Carry catches add/subtract overflow, rotate shift-out, bit accumulator.
// RQ14: Stack pointer is 16 bits, bit 0 always reads zero.
// RQ15: Stack pointer decremented before save, incremented after restore.
// RQ16: Software loads stack pointer before any stack use.
// RQ17: Software keeps stack in internal RAM, outside working registers.
// RQ18: Four banks of eight bytes map to FFEE0H..FFEFFH, pairs usable.
// RQ19: Extension registers supply upper bits; reset values 0FH and 00H.
// RQ20: 16-bit data addresses reach top 64K; extension reaches full range.
// RQ21: Software uses supported widths and even addresses for 16-bit access.
// RQ22: Software avoids unassigned peripheral register addresses.
// RQ23: Flag writes take effect at the next instruction boundary.
module cpu_control_register_set
  import cpu_regs_pkg::*;
(
  input  wire logic        clk_i,          // Core clock
  input  wire logic        rst_n_i,        // Synchronous reset, active low
  // Reset vector fetch from code memory
  output logic [19:0]      vec_addr_o,     // Code address during vector load
  output logic             vec_rd_o,       // Vector fetch strobe
  input  wire logic [7:0]  vec_data_i,     // Code byte, valid same cycle
  // Instruction sequencing
  input  wire pc_op_t      pc_op_i,        // Counter operation
  input  wire logic [2:0]  instr_len_i,    // Fetched instruction bytes
  input  wire logic [19:0] br_imm_i,       // Immediate branch target
  input  wire logic [15:0] br_reg_i,       // Register branch low part
  output logic [19:0]      pc_o,           // Instruction address counter
  output logic             ready_o,        // Vector load complete
  // Flag word
  input  wire flag_req_t   flag_req_i,     // Flag update request
  output logic [7:0]       flags_o,        // Flag word
  // Interrupt acceptance
  input  wire logic        irq_req_i,      // Unmasked maskable request
  input  wire logic [1:0]  irq_prio_i,     // Its programmed priority
  output logic             irq_ok_o,       // Request may be accepted
  // Stack pointer
  input  wire sp_op_t      sp_op_i,        // Stack pointer operation
  input  wire logic [15:0] sp_wdata_i,     // Load value
  output logic [15:0]      sp_o,           // Stack pointer, bit 0 zero
  output logic [15:0]      push_addr_o,    // Address for a save
  // Extension registers
  input  wire logic        dext_we_i,      // Data extension write
  input  wire logic        cext_we_i,      // Code extension write
  input  wire logic [3:0]  ext_wdata_i,    // Extension write data
  output logic [3:0]       dext_o,         // Data extension value
  output logic [3:0]       cext_o,         // Code extension value
  // Data address formation
  input  wire logic [15:0] daddr_i,        // 16-bit data address
  input  wire logic        use_dext_i,     // Combine data extension
  output logic [19:0]      daddr_o,        // Full 20-bit data address
  output logic             in_wreg_o,      // Address hits register window
  // Working registers
  input  wire wreg_req_t   wreg_req_i,     // Named access
  input  wire logic        mem_we_i,       // Byte write by data address
  input  wire logic [7:0]  mem_wdata_i,    // Byte write data
  output logic [15:0]      wreg_rdata_o,   // Named read data
  output logic [7:0]       mem_rdata_o     // Byte read for window hits
);

  // Vector load sequence
  typedef enum logic [1:0] {
    ST_VLO = 2'b00,
    ST_VHI = 2'b01,
    ST_RUN = 2'b10
  } st_t;

  st_t         st_q, st_d;
  logic [19:0] pc_q, pc_d;
  logic [7:0]  vlo_q, vlo_d;
  logic [7:0]  fl_q, fl_d;
  logic [15:0] sp_q, sp_d;
  logic [3:0]  dx_q, dx_d;
  logic [3:0]  cx_q, cx_d;
  logic        ok_q, ok_d;
  logic [19:0] va_q, va_d;
  logic        vr_q, vr_d;
  logic        rdy_q, rdy_d;
  logic [15:0] pa_q, pa_d;
  logic [19:0] da_q, da_d;
  logic        iw_q, iw_d;
  logic [19:0] da_c;
  logic [4:0]  wofs;
  logic        whit;
  logic [15:0] wr_rd;
  logic [7:0]  mr_rd;

  // Sequencing: vector bytes are read while held in reset-release
  always_comb begin
    st_d  = st_q;
    pc_d  = pc_q;
    vlo_d = vlo_q;
    va_d  = va_q;
    vr_d  = 1'b0;
    unique case (st_q)
      ST_VLO: begin
        vlo_d = vec_data_i;                         // [RQ2]
        va_d  = VEC_HI_A;
        vr_d  = 1'b1;
        st_d  = ST_VHI;
      end
      ST_VHI: begin
        pc_d = {4'h0, vec_data_i, vlo_q};           // [RQ2]
        st_d = ST_RUN;
      end
      ST_RUN: begin
        unique case (pc_op_i)
          PC_HOLD:   pc_d = pc_q;
          PC_SEQ:    pc_d = pc_q + {17'h0, instr_len_i}; // [RQ1]
          PC_BR_IMM: pc_d = br_imm_i;                    // [RQ3]
          PC_BR_REG: pc_d = {cx_q, br_reg_i};            // [RQ3] [RQ19]
        endcase
      end
      default: st_d = ST_VLO;
    endcase
    if (!rst_n_i) begin
      st_d = ST_VLO;
      va_d = VEC_LO_A;
      vr_d = 1'b1;
    end
    // Ready is registered so the output comes straight from a flop
    rdy_d = (st_d == ST_RUN);
  end

  // Flag word: acceptance and disable clear the gate, enable sets it
  always_comb begin
    fl_d = fl_q;
    if (st_q == ST_RUN) begin
      if (flag_req_i.wr_all) begin
        fl_d = flag_req_i.wr_val;                   // [RQ6]
      end
      if (flag_req_i.upd_z) begin
        fl_d[F_Z] = (flag_req_i.result == 8'h00);   // [RQ9]
      end
      if (flag_req_i.upd_hc) begin
        fl_d[F_HC] = flag_req_i.hc_out;             // [RQ11]
      end
      if (flag_req_i.upd_cy) begin
        fl_d[F_CY] = flag_req_i.cy_val;             // [RQ13]
      end
      if (flag_req_i.bank_wr) begin
        fl_d[F_BS1] = flag_req_i.bank_val[1];       // [RQ10]
        fl_d[F_BS0] = flag_req_i.bank_val[0];
      end
      if (flag_req_i.gate_on) begin
        fl_d[F_IG] = 1'b1;                          // [RQ8]
      end
      if (flag_req_i.gate_off || flag_req_i.irq_taken) begin
        fl_d[F_IG] = 1'b0;                          // [RQ8]
      end
    end
    if (!rst_n_i) begin
      fl_d = FLAGS_RST;                             // [RQ4]
    end
  end

  // Acceptance uses the registered flags, so a write counts next boundary
  always_comb begin
    ok_d = irq_req_i && fl_q[F_IG]                  // [RQ7] [RQ23]
           && (irq_prio_i <= {fl_q[F_SL1], fl_q[F_SL0]}) // [RQ12]
           && (st_q == ST_RUN);
    if (!rst_n_i) begin
      ok_d = 1'b0;
    end
  end

  // Stack pointer: save uses the pre-decremented address
  always_comb begin
    sp_d = sp_q;
    pa_d = pa_q;
    unique case (sp_op_i)
      SP_HOLD: sp_d = sp_q;
      SP_LOAD: sp_d = {sp_wdata_i[15:1], 1'b0};     // [RQ14]
      SP_PUSH: begin
        sp_d = sp_q - {14'h0, STACK_STEP};          // [RQ15]
        pa_d = sp_q - {14'h0, STACK_STEP};
      end
      SP_POP:  sp_d = sp_q + {14'h0, STACK_STEP};   // [RQ15]
    endcase
    sp_d[0] = 1'b0;                                 // [RQ14]
    if (!rst_n_i) begin
      sp_d = 16'h0000;                              // Software must load it
      pa_d = 16'h0000;
    end
  end

  // Extension registers and data address formation
  always_comb begin
    dx_d = dext_we_i ? ext_wdata_i : dx_q;
    cx_d = cext_we_i ? ext_wdata_i : cx_q;
    da_c = {use_dext_i ? dx_q : TOP_SEG, daddr_i};  // [RQ19] [RQ20]
    whit = (da_c >= WREG_BASE) && (da_c <= WREG_LAST); // [RQ18]
    wofs = 5'(da_c - WREG_BASE);
    da_d = da_c;
    iw_d = whit;
    if (!rst_n_i) begin
      dx_d = DEXT_RST;                              // [RQ19]
      cx_d = CEXT_RST;
      da_d = 20'h00000;
      iw_d = 1'b0;
    end
  end

  // Sequencing state: vector fetch, counter and ready
  always_ff @(posedge clk_i) begin
    st_q  <= st_d;
    pc_q  <= pc_d;
    vlo_q <= vlo_d;
    va_q  <= va_d;
    vr_q  <= vr_d;
    rdy_q <= rdy_d;
  end

  // Flag word and the acceptance decision built from it
  always_ff @(posedge clk_i) begin
    fl_q <= fl_d;
    ok_q <= ok_d;
  end

  // Stack pointer and the address of the last save
  always_ff @(posedge clk_i) begin
    sp_q <= sp_d;
    pa_q <= pa_d;
  end

  // Extension registers and registered data address
  always_ff @(posedge clk_i) begin
    dx_q <= dx_d;
    cx_q <= cx_d;
    da_q <= da_d;
    iw_q <= iw_d;
  end

  // Banks follow the registered bank bits of the flag word
  work_reg_banks work_reg_banks_i (
    .clk_i       (clk_i),
    .bank_i      ({fl_q[F_BS1], fl_q[F_BS0]}),       // [RQ10]
    .req_i       (wreg_req_i),
    .mem_we_i    (mem_we_i && whit),                 // [RQ18]
    .mem_ofs_i   (wofs),
    .mem_wdata_i (mem_wdata_i),
    .rdata_o     (wr_rd),
    .mem_rdata_o (mr_rd)
  );

  // Register read data so outputs come from flip-flops
  logic [15:0] wr_q;
  logic [7:0]  mr_q;
  always_ff @(posedge clk_i) begin
    wr_q <= rst_n_i ? wr_rd : 16'h0000;
    mr_q <= rst_n_i ? mr_rd : 8'h00;
  end

  // Outputs
  assign vec_addr_o   = va_q;
  assign vec_rd_o     = vr_q;
  assign pc_o         = pc_q;
  assign ready_o      = rdy_q;
  assign flags_o      = fl_q;                        // [RQ5]
  assign irq_ok_o     = ok_q;
  assign sp_o         = sp_q;
  assign push_addr_o  = pa_q;
  assign dext_o       = dx_q;
  assign cext_o       = cx_q;
  assign daddr_o      = da_q;
  assign in_wreg_o    = iw_q;
  assign wreg_rdata_o = wr_q;
  assign mem_rdata_o  = mr_q;

endmodule : cpu_control_register_set

// >>> tb/cpu_regs_sva.sv
module cpu_regs_sva
  import cpu_regs_pkg::*;
(
  input wire logic        clk_i,       // Core clock
  input wire logic        rst_n_i,     // Reset, active low
  input wire logic [19:0] vec_addr_o,  // Vector fetch address
  input wire logic        ready_o,     // Vector load done
  input wire pc_op_t      pc_op_i,     // Counter operation
  input wire logic [2:0]  instr_len_i, // Instruction bytes
  input wire logic [19:0] br_imm_i,    // Immediate target
  input wire logic [19:0] pc_o,        // Counter
  input wire flag_req_t   flag_req_i,  // Flag request
  input wire logic [7:0]  flags_o,     // Flag word
  input wire logic        irq_req_i,   // Maskable request
  input wire logic [1:0]  irq_prio_i,  // Its priority
  input wire logic        irq_ok_o,    // Acceptance
  input wire sp_op_t      sp_op_i,     // Stack operation
  input wire logic [15:0] sp_o,        // Stack pointer
  input wire logic [15:0] push_addr_o, // Save address
  input wire logic [3:0]  dext_o,      // Data extension
  input wire logic [3:0]  cext_o       // Code extension
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Values seen on the first edge out of reset
  chk_reset_vals: assert property (
    $rose(rst_n_i) |-> flags_o == FLAGS_RST && dext_o == DEXT_RST
      && cext_o == CEXT_RST) else $error("reset values wrong");
  // Low byte address first, then high byte, then ready
  chk_vector_load: assert property (
    $rose(rst_n_i) |-> vec_addr_o == VEC_LO_A ##1 vec_addr_o == VEC_HI_A
      ##1 ready_o) else $error("vector fetch order wrong");
  chk_pc_advance: assert property (
    ready_o && pc_op_i == PC_SEQ |=> pc_o == $past(pc_o + 20'(instr_len_i)))
    else $error("counter did not advance by length");
  chk_pc_branch: assert property (
    ready_o && pc_op_i == PC_BR_IMM |=> pc_o == $past(br_imm_i))
    else $error("immediate branch not taken");
  chk_gate_set: assert property (
    ready_o && flag_req_i.gate_on && !flag_req_i.gate_off
      && !flag_req_i.irq_taken |=> flags_o[F_IG])
    else $error("gate not set");
  chk_gate_clear: assert property (
    ready_o && (flag_req_i.gate_off || flag_req_i.irq_taken)
      |=> !flags_o[F_IG]) else $error("gate not cleared");
  // Acceptance needs the gate and a priority within the service level
  chk_irq_accept: assert property (
    1'b1 |=> irq_ok_o == $past(irq_req_i && flags_o[F_IG]
      && irq_prio_i <= flags_o[F_SL1:F_SL0]))
    else $error("acceptance decision wrong");
  chk_push_decr: assert property (
    sp_op_i == SP_PUSH |=> sp_o == $past(sp_o) - 16'h0002
      && push_addr_o == sp_o) else $error("save did not predecrement");

  cov_push: cover property (sp_op_i == SP_PUSH);
  cov_accept: cover property (irq_ok_o);
  cov_branch: cover property (ready_o && pc_op_i == PC_BR_IMM);
endmodule : cpu_regs_sva

// >>> tb/cpu_control_register_set_tb_top.sv
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  n_mismatch++; $display("[ERR] %s exp %h got %h", nm, e, g); end end

module cpu_control_register_set_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cpu_regs_pkg::*;

  logic clk_i, rst_n_i, vec_rd_o, ready_o, irq_req_i, irq_ok_o;
  logic dext_we_i, cext_we_i, use_dext_i, in_wreg_o, mem_we_i;
  logic [19:0] vec_addr_o, br_imm_i, pc_o, daddr_o;
  logic [7:0]  vec_data_i, flags_o, mem_wdata_i, mem_rdata_o;
  logic [15:0] br_reg_i, sp_wdata_i, sp_o, push_addr_o, daddr_i;
  logic [15:0] wreg_rdata_o;
  logic [3:0]  ext_wdata_i, dext_o, cext_o;
  logic [2:0]  instr_len_i;
  logic [1:0]  irq_prio_i;
  pc_op_t      pc_op_i;
  sp_op_t      sp_op_i;
  flag_req_t   flag_req_i, f;
  wreg_req_t   wreg_req_i;
  int          n_mismatch, compares, cyc;

  cpu_control_register_set cpu_control_register_set_i (.*);

  // Vector entry 01234h held at the lowest code addresses
  assign vec_data_i = (vec_addr_o == VEC_HI_A) ? 8'h12 : 8'h34;

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Cut a hang short well past the expected run length
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic close_out();
    if (n_mismatch == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  task automatic step();
    @(posedge clk_i);
    #1;
  endtask : step

  task automatic wait_ready();
    for (int k = 0; k < 8 && ready_o !== 1'b1; k++) step();
    `CHK("ready", 1'b1, ready_o)
  endtask : wait_ready

  task automatic flag_op(input flag_req_t r);
    flag_req_i = r;
    step();
    flag_req_i = '0;
  endtask : flag_op

  task automatic pc_do(input pc_op_t op, input logic [2:0] len,
                       input logic [19:0] exp);
    pc_op_i     = op;
    instr_len_i = len;
    step();
    pc_op_i = PC_HOLD;
    `CHK("pc", exp, pc_o)
  endtask : pc_do

  initial begin
    rst_n_i = 1'b0;
    {irq_req_i, dext_we_i, cext_we_i, use_dext_i, mem_we_i} = '0;
    {br_imm_i, br_reg_i, sp_wdata_i, daddr_i} = '0;
    {mem_wdata_i, ext_wdata_i, instr_len_i, irq_prio_i} = '0;
    pc_op_i = PC_HOLD;
    sp_op_i = SP_HOLD;
    flag_req_i = '0;
    wreg_req_i = '0;
    repeat (20) step();
    `CHK("vec_rd", 1'b1, vec_rd_o)
    rst_n_i = 1'b1;
    wait_ready();
    `CHK("pc", 20'h01234, pc_o)
    `CHK("flags", 8'h06, flags_o)
    `CHK("dext", 4'hf, dext_o)
    `CHK("vec_rd", 1'b0, vec_rd_o)
    `CHK("cext", 4'h0, cext_o)
    pc_do(PC_SEQ, 3'd2, 20'h01236);
    pc_do(PC_SEQ, 3'd4, 20'h0123a);
    br_imm_i = 20'hfedcb;
    pc_do(PC_BR_IMM, 3'd0, 20'hfedcb);
    cext_we_i = 1'b1;
    ext_wdata_i = 4'h3;
    step();
    cext_we_i = 1'b0;
    br_reg_i = 16'habcd;
    pc_do(PC_BR_REG, 3'd0, 20'h3abcd);
    // Gate, service level and priority against acceptance
    f = '0; f.gate_on = 1'b1; flag_op(f);
    `CHK("flags", 8'h86, flags_o)
    irq_req_i = 1'b1; irq_prio_i = 2'd3; step();
    `CHK("irq_ok", 1'b1, irq_ok_o)
    f = '0; f.wr_all = 1'b1; f.wr_val = 8'h80; flag_op(f);
    irq_prio_i = 2'd1; step();
    `CHK("irq_ok", 1'b0, irq_ok_o)
    irq_prio_i = 2'd0; step();
    `CHK("irq_ok", 1'b1, irq_ok_o)
    f = '0; f.gate_off = 1'b1; flag_op(f);
    step();
    `CHK("irq_ok", 1'b0, irq_ok_o)
    irq_req_i = 1'b0;
    f = '0; f.gate_on = 1'b1; flag_op(f);
    f = '0; f.irq_taken = 1'b1; flag_op(f);
    `CHK("gate", 1'b0, flags_o[F_IG])
    // Updates override a whole-word load in the same cycle
    for (int i = 0; i < 2; i++) begin
      f = '0; f.wr_all = 1'b1; f.upd_z = 1'b1; f.upd_hc = 1'b1;
      f.upd_cy = 1'b1; f.bank_wr = 1'b1;
      f.result = (i == 1) ? 8'h05 : 8'h00;
      f.hc_out = (i == 0); f.cy_val = (i == 0);
      f.bank_val = (i == 1) ? 2'b01 : 2'b10;
      flag_op(f);
      `CHK("flags", (i == 1) ? 8'h08 : 8'h71,
           flags_o)
    end
    f = '0; f.wr_all = 1'b1; f.wr_val = 8'hc9; flag_op(f);
    `CHK("flags", 8'hc9, flags_o)
    // Stack pointer keeps bit 0 clear through load, save and restore
    sp_op_i = SP_LOAD; sp_wdata_i = 16'hfe11; step();
    `CHK("sp", 16'hfe10, sp_o)
    sp_op_i = SP_PUSH; step();
    `CHK("push", 16'hfe0e, push_addr_o)
    sp_op_i = SP_POP; step();
    sp_op_i = SP_HOLD;
    `CHK("sp", 16'hfe10, sp_o)
    daddr_i = 16'hfee0; step();
    `CHK("daddr", 20'hffee0, daddr_o)
    `CHK("in_wreg", 1'b1, in_wreg_o)
    dext_we_i = 1'b1; ext_wdata_i = 4'h2; step();
    dext_we_i = 1'b0; use_dext_i = 1'b1; daddr_i = 16'h1234; step();
    `CHK("daddr", 20'h21234, daddr_o)
    `CHK("in_wreg", 1'b0, in_wreg_o)
    // Bank 1 pair 1 sits at window offsets 0ah and 0bh
    use_dext_i = 1'b0;
    wreg_req_i = '{we: 1'b1, pair: 1'b1, idx: 3'd2, wdata: 16'hbeef};
    step();
    wreg_req_i.we = 1'b0; daddr_i = 16'hfeea; step();
    `CHK("wreg", 16'hbeef, wreg_rdata_o)
    `CHK("mem", 8'hef, mem_rdata_o)
    mem_we_i = 1'b1; mem_wdata_i = 8'h5a; daddr_i = 16'hfeeb; step();
    mem_we_i = 1'b0; step();
    `CHK("wreg", 16'h5aef, wreg_rdata_o)
    // Reset again in mid-run
    rst_n_i = 1'b0; repeat (3) step();
    rst_n_i = 1'b1;
    wait_ready();
    `CHK("flags", 8'h06, flags_o)
    `CHK("pc", 20'h01234, pc_o)
    close_out();
  end
endmodule : cpu_control_register_set_tb_top

bind cpu_control_register_set cpu_regs_sva cpu_regs_sva_i (.*);
